// *** common/txm_defines.svh ***
// register offsets, field positions, reset values and format constants for the tx modulator config
`ifndef TXM_DEFINES_SVH
`define TXM_DEFINES_SVH
`define TXM_ADDR_MOD_UPPER 6'h13
`define TXM_ADDR_MOD_LOWER 6'h14
`define TXM_ADDR_DEVIATION 6'h15
`define TXM_ADDR_SM_CONFIG 6'h17
`define TXM_FEC_BIT 7
`define TXM_PRE_MSB 6
`define TXM_PRE_LSB 4
`define TXM_SPE_MSB 1
`define TXM_SPE_LSB 0
`define TXM_DEVE_MSB 6
`define TXM_DEVE_LSB 4
`define TXM_DEVM_MSB 2
`define TXM_DEVM_LSB 0
`define TXM_PTS_MSB 1
`define TXM_PTS_LSB 0
`define TXM_RST_FEC 1'h0
`define TXM_RST_PRE 3'h2
`define TXM_RST_SPE 2'h2
`define TXM_RST_SPM 8'hF8
`define TXM_RST_DEVE 3'h4
`define TXM_RST_DEVM 3'h7
`define TXM_RST_PTS 2'h0
`define TXM_SPM_BASE 9'h100
`define TXM_DEVM_BASE 4'h8
`define TXM_SP_SHIFT 18
`define TXM_DEV_SHIFT 17
`endif

// *** common/txm_pkg.sv ***
// types shared by the tx modulator configuration block
package txm_pkg;
  typedef enum logic [1:0] {
    TXM_OFF_IDLE,
    TXM_OFF_SYNTH_ON,
    TXM_OFF_STAY_TX,
    TXM_OFF_UNUSED
  } txm_post_t;

  typedef struct packed {
    logic error_correction_enable; // payload fec with interleaving
    logic [2:0] preamble_code; // minimum preamble code
    logic [1:0] spacing_exponent; // channel spacing exponent
    logic [7:0] spacing_mantissa; // channel spacing mantissa
    logic [2:0] deviation_exponent; // deviation exponent
    logic [2:0] deviation_mantissa; // deviation mantissa or msk fraction
    txm_post_t post_transmit_state; // state after a packet
  } txm_cfg_t;

  typedef struct packed {
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [5:0] addr; // register address
    logic [7:0] wdata; // write data
  } txm_req_t;
endpackage

// *** design/txm_config_regs.sv ***
// configuration registers of the transmit modulator and post-transmit control
// Function
// - fec enable bit turns on payload coding
// - preamble code maps to 2..24 bytes
// - channel offset from spacing mantissa, exponent, channel
// - spacing mantissa full byte, reset 0xF8
// - fsk deviation from mantissa plus eight, exponent
// - msk uses mantissa as phase-change fraction
// - post-transmit field picks idle, synth, or tx
module txm_config_regs #(
  parameter int CHANNEL_NUMBER_W = 8,
  parameter int OUT_W = 30
) (
  input wire logic clock, // 100 mhz clock
  input wire logic srst, // synchronous reset, active high
  input txm_pkg::txm_req_t req, // register access from the serial port
  output logic [7:0] rdata, // read data, registered
  output logic rvalid, // read data valid, one cycle pulse
  input wire logic [CHANNEL_NUMBER_W-1:0] channel_number, // channel from its own register
  input wire logic msk_mode, // msk modulation selected
  input wire logic packet_done, // one-cycle pulse at end of packet
  output txm_pkg::txm_cfg_t cfg, // decoded configuration fields
  output logic [4:0] preamble_bytes, // minimum preamble bytes, registered
  output logic [2:0] msk_fraction, // msk phase-change fraction, 0 when fsk
  output logic [OUT_W-1:0] channel_offset, // offset added to base frequency
  output logic [OUT_W-1:0] deviation_step, // fsk deviation, 0 when msk
  output logic go_idle, // pulse: enter idle after packet
  output logic go_synth_on, // pulse: enter synth_on_tx_ready
  output logic restart_preamble // pulse: stay in tx, send preamble
);
  import txm_pkg::*;
  `include "txm_defines.svh"

  logic [OUT_W-1:0] dev_raw; // deviation before mode gating
  logic [7:0] next_rdata; // read mux output
  logic error_correction_enable; // fec bit of the upper register
  logic [2:0] preamble_code; // minimum preamble code
  logic [1:0] spacing_exponent; // channel spacing exponent
  logic [7:0] spacing_mantissa; // channel spacing mantissa
  logic [2:0] deviation_exponent; // deviation exponent
  logic [2:0] deviation_mantissa; // deviation mantissa or msk fraction
  txm_post_t post_transmit_state; // follow-up state after a packet

  // one driver for the whole bundle; every field still comes straight from a flip-flop
  assign cfg = '{
    error_correction_enable: error_correction_enable,
    preamble_code: preamble_code,
    spacing_exponent: spacing_exponent,
    spacing_mantissa: spacing_mantissa,
    deviation_exponent: deviation_exponent,
    deviation_mantissa: deviation_mantissa,
    post_transmit_state: post_transmit_state
  };

  // upper modulator register: fec, preamble, spacing exponent
  always_ff @(posedge clock) begin
    if (srst) begin
      error_correction_enable <= `TXM_RST_FEC;
      preamble_code <= `TXM_RST_PRE;
      spacing_exponent <= `TXM_RST_SPE;
    end else if (req.wr && req.addr == `TXM_ADDR_MOD_UPPER) begin
      error_correction_enable <= req.wdata[`TXM_FEC_BIT];
      preamble_code <= req.wdata[`TXM_PRE_MSB:`TXM_PRE_LSB];
      // bits 3:2 are not stored, so nothing written there can matter
      spacing_exponent <= req.wdata[`TXM_SPE_MSB:`TXM_SPE_LSB];
    end
  end

  // lower modulator register: whole byte is the spacing mantissa
  always_ff @(posedge clock) begin
    if (srst) begin
      spacing_mantissa <= `TXM_RST_SPM;
    end else if (req.wr && req.addr == `TXM_ADDR_MOD_LOWER) begin
      spacing_mantissa <= req.wdata;
    end
  end

  // deviation register; bits 7 and 3 are not stored
  always_ff @(posedge clock) begin
    if (srst) begin
      deviation_exponent <= `TXM_RST_DEVE;
      deviation_mantissa <= `TXM_RST_DEVM;
    end else if (req.wr && req.addr == `TXM_ADDR_DEVIATION) begin
      deviation_exponent <= req.wdata[`TXM_DEVE_MSB:`TXM_DEVE_LSB];
      deviation_mantissa <= req.wdata[`TXM_DEVM_MSB:`TXM_DEVM_LSB];
    end
  end

  // state machine config; a code 3 write is stored but treated as idle below
  always_ff @(posedge clock) begin
    if (srst) begin
      post_transmit_state <= TXM_OFF_IDLE;
    end else if (req.wr && req.addr == `TXM_ADDR_SM_CONFIG) begin
      post_transmit_state <= txm_post_t'(req.wdata[`TXM_PTS_MSB:`TXM_PTS_LSB]);
    end
  end

  // read mux; reserved positions and unmapped addresses return zero
  always_comb begin
    unique case (req.addr)
      `TXM_ADDR_MOD_UPPER: next_rdata = {cfg.error_correction_enable, cfg.preamble_code,
                                         2'h0, cfg.spacing_exponent};
      `TXM_ADDR_MOD_LOWER: next_rdata = cfg.spacing_mantissa;
      `TXM_ADDR_DEVIATION: next_rdata = {1'b0, cfg.deviation_exponent,
                                         1'b0, cfg.deviation_mantissa};
      `TXM_ADDR_SM_CONFIG: next_rdata = {6'h00, cfg.post_transmit_state};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data is registered and answered one cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // preamble code to byte count
  always_ff @(posedge clock) begin
    if (srst) begin
      preamble_bytes <= 5'h04;
    end else begin
      unique case (cfg.preamble_code)
        3'h0: preamble_bytes <= 5'h02;
        3'h1: preamble_bytes <= 5'h03;
        3'h2: preamble_bytes <= 5'h04;
        3'h3: preamble_bytes <= 5'h06;
        3'h4: preamble_bytes <= 5'h08;
        3'h5: preamble_bytes <= 5'h0C;
        3'h6: preamble_bytes <= 5'h10;
        3'h7: preamble_bytes <= 5'h18;
      endcase
    end
  end

  // the mantissa means the phase-change fraction in msk, deviation otherwise
  always_ff @(posedge clock) begin
    if (srst) begin
      msk_fraction <= 3'h0;
      deviation_step <= '0;
    end else begin
      msk_fraction <= msk_mode ? cfg.deviation_mantissa : 3'h0;
      deviation_step <= msk_mode ? '0 : dev_raw;
    end
  end

  // next-state request after a packet; code 3 falls back to idle for safety
  always_ff @(posedge clock) begin
    if (srst) begin
      go_idle <= 1'b0;
      go_synth_on <= 1'b0;
      restart_preamble <= 1'b0;
    end else begin
      go_idle <= packet_done && (cfg.post_transmit_state == TXM_OFF_IDLE
                                 || cfg.post_transmit_state == TXM_OFF_UNUSED);
      go_synth_on <= packet_done && cfg.post_transmit_state == TXM_OFF_SYNTH_ON;
      restart_preamble <= packet_done && cfg.post_transmit_state == TXM_OFF_STAY_TX;
    end
  end

  // frequency arithmetic shared by both modulation formats
  txm_freq_calc #(
    .CHANNEL_NUMBER_W(CHANNEL_NUMBER_W),
    .OUT_W(OUT_W)
  ) u_calc (
    .clock(clock),
    .srst(srst),
    .spacing_mantissa(cfg.spacing_mantissa),
    .spacing_exponent(cfg.spacing_exponent),
    .channel_number(channel_number),
    .deviation_mantissa(cfg.deviation_mantissa),
    .deviation_exponent(cfg.deviation_exponent),
    .channel_offset(channel_offset),
    .deviation_step(dev_raw)
  );
endmodule // txm_config_regs

// *** design/txm_freq_calc.sv ***
// channel offset and fsk deviation arithmetic in units of fxosc / 2^18
module txm_freq_calc #(
  parameter int CHANNEL_NUMBER_W = 8,
  parameter int OUT_W = 30
) (
  input wire logic clock, // 100 mhz clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] spacing_mantissa, // spacing mantissa
  input wire logic [1:0] spacing_exponent, // spacing exponent
  input wire logic [CHANNEL_NUMBER_W-1:0] channel_number, // selected channel
  input wire logic [2:0] deviation_mantissa, // deviation mantissa
  input wire logic [2:0] deviation_exponent, // deviation exponent
  output logic [OUT_W-1:0] channel_offset, // offset, lsb = fxosc/2^18
  output logic [OUT_W-1:0] deviation_step // deviation, lsb = fxosc/2^18
);
  import txm_pkg::*;
  `include "txm_defines.svh"

  logic [8:0] spacing_full; // mantissa with implied leading one
  logic [3:0] dev_full; // deviation mantissa with implicit msb
  logic [OUT_W-1:0] next_offset; // combinational offset
  logic [OUT_W-1:0] next_dev; // combinational deviation

  // (256 + m) * 2^e * channel_number, expressed against fxosc/2^18
  always_comb begin
    spacing_full = `TXM_SPM_BASE + {1'b0, spacing_mantissa};
    next_offset = OUT_W'((OUT_W'(spacing_full) << spacing_exponent) * OUT_W'(channel_number));
  end

  // (8 + m) * 2^e against fxosc/2^17; one extra shift puts it on the 2^18 scale
  always_comb begin
    dev_full = `TXM_DEVM_BASE + {1'b0, deviation_mantissa};
    next_dev = OUT_W'((OUT_W'(dev_full) << deviation_exponent) << 1);
  end

  // registered so the multiplier path does not reach outputs directly
  always_ff @(posedge clock) begin
    if (srst) begin
      channel_offset <= '0;
      deviation_step <= '0;
    end else begin
      channel_offset <= next_offset;
      deviation_step <= next_dev;
    end
  end
endmodule // txm_freq_calc

// *** testbench/tb_txm_config_regs.sv ***
// self-checking bench for the tx modulator configuration registers
module tb_txm_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import txm_pkg::*;
  logic clock, srst, rvalid, msk_mode, packet_done, go_idle, go_synth_on, restart_preamble;
  txm_req_t req; // register access
  txm_cfg_t cfg; // live fields
  logic [7:0] rdata, channel_number;
  logic [4:0] preamble_bytes;
  logic [2:0] msk_fraction;
  logic [29:0] channel_offset, deviation_step;
  int n_fail, n_compared;
  localparam logic [4:0] PB [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  localparam logic [2:0] PT [3] = '{3'h4, 3'h2, 3'h1}; // idle, synth, tx pulse patterns
  txm_config_regs DUT (.clock(clock), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .channel_number(channel_number), .msk_mode(msk_mode), .packet_done(packet_done),
    .cfg(cfg), .preamble_bytes(preamble_bytes), .msk_fraction(msk_fraction),
    .channel_offset(channel_offset), .deviation_step(deviation_step), .go_idle(go_idle),
    .go_synth_on(go_synth_on), .restart_preamble(restart_preamble));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // four-state compare so an unknown never matches
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // wait whole cycles, then step past the edge so outputs are settled
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask
  // read with a bounded wait for the answer strobe
  task rd(input logic [5:0] a, input logic [7:0] e);
    int n;
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) tick(1);
    if (n == 4) begin
      chk("read timeout", 0, 1);
      final_report;
    end
    chk("rdata", {24'h0, rdata}, {24'h0, e});
  endtask
  initial begin
    srst = 1'b1;
    req = '0;
    channel_number = 8'h00;
    msk_mode = 1'b0;
    packet_done = 1'b0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd(6'h13, 8'h22);
    rd(6'h14, 8'hF8);
    rd(6'h15, 8'h47);
    rd(6'h17, 8'h00);
    $display("test reset values done");
    // reserved bits read zero; unmapped writes land nowhere
    wr(6'h13, 8'hFF);
    wr(6'h16, 8'hFF);
    rd(6'h13, 8'hF3);
    chk("fec", cfg.error_correction_enable, 1);
    wr(6'h15, 8'hFF);
    rd(6'h15, 8'h77);
    rd(6'h16, 8'h00);
    $display("test reserved done");
    for (int c = 0; c < 8; c++) begin
      wr(6'h13, {1'b0, 3'(c), 4'h2});
      tick(1);
      chk("preamble_bytes", preamble_bytes, PB[c]);
    end
    chk("fec", cfg.error_correction_enable, 0);
    $display("test preamble done");
    // offset: (256 + m) << e times channel, both plain and full-scale
    wr(6'h14, 8'h10);
    wr(6'h13, 8'h01);
    channel_number <= 8'h03;
    tick(3);
    chk("channel_offset", channel_offset, 32'd1632);
    wr(6'h14, 8'hFF);
    wr(6'h13, 8'h03);
    channel_number <= 8'hFF;
    tick(3);
    chk("channel_offset", channel_offset, 32'd1042440);
    $display("test channel offset done");
    wr(6'h15, 8'h25);
    tick(3);
    chk("deviation_step", deviation_step, 32'd104);
    chk("msk_fraction", msk_fraction, 0);
    @(posedge clock);
    msk_mode <= 1'b1;
    tick(3);
    chk("msk_fraction", msk_fraction, 5);
    chk("deviation_step", deviation_step, 0);
    @(posedge clock);
    msk_mode <= 1'b0;
    $display("test deviation done");
    // code three is never written: the host must not request it
    for (int k = 0; k < 3; k++) begin
      wr(6'h17, 8'(k));
      packet_done <= 1'b1;
      @(posedge clock);
      packet_done <= 1'b0;
      #1;
      chk("next state", {go_idle, go_synth_on, restart_preamble}, PT[k]);
    end
    $display("test post transmit done");
    final_report;
  end
endmodule // tb_txm_config_regs

// *** testbench/txm_chk.sv ***
// assertion checker for the tx modulator configuration registers
module txm_chk import txm_pkg::*; #(
  parameter int CHANNEL_NUMBER_W = 8,
  parameter int OUT_W = 30
) (
  input wire logic clock, // clock
  input wire logic srst, // sync reset
  input txm_pkg::txm_req_t req, // register access
  input wire logic rvalid, // read answer
  input wire logic msk_mode, // msk selected
  input wire logic packet_done, // end of packet
  input txm_pkg::txm_cfg_t cfg, // live fields
  input wire logic [4:0] preamble_bytes, // preamble count
  input wire logic [2:0] msk_fraction, // msk fraction
  input wire logic [OUT_W-1:0] deviation_step, // fsk deviation
  input wire logic go_idle, // to idle
  input wire logic go_synth_on, // to synth on
  input wire logic restart_preamble // stay in tx
);
  timeunit 1ns;
  timeprecision 100ps;
  // code to byte count, index 0 first
  localparam logic [4:0] PB [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // end of packet with a given follow-up code
  sequence s_end(txm_post_t k);
    packet_done && cfg.post_transmit_state == k;
  endsequence
  a_read_answer: assert property (req.rd |=> rvalid) else $error("no read answer");
  a_write_fec: assert property (req.wr && req.addr == 6'h13 |=>
    cfg.error_correction_enable == $past(req.wdata[7])) else $error("fec bit not written");
  a_write_mant: assert property (req.wr && req.addr == 6'h14 |=>
    cfg.spacing_mantissa == $past(req.wdata)) else $error("mantissa not written");
  a_mant_hold: assert property (!(req.wr && req.addr == 6'h14) |=>
    $stable(cfg.spacing_mantissa)) else $error("mantissa changed unasked");
  a_pre_map: assert property (preamble_bytes == PB[$past(cfg.preamble_code)])
    else $error("preamble byte count wrong");
  a_msk_frac: assert property (!$past(srst) |-> msk_fraction ==
    ($past(msk_mode) ? $past(cfg.deviation_mantissa) : 3'h0)) else $error("msk fraction wrong");
  // two-stage latency; only checked while fsk has held
  a_dev_step: assert property (!$past(srst, 2) && !$past(srst) && !$past(msk_mode, 2)
    && !$past(msk_mode) |-> deviation_step == ((OUT_W'({1'b1, $past(cfg.deviation_mantissa, 2)})
    << $past(cfg.deviation_exponent, 2)) << 1)) else $error("deviation wrong");
  a_post_idle: assert property (s_end(TXM_OFF_IDLE) |=> go_idle && !restart_preamble)
    else $error("idle not chosen");
  a_post_synth: assert property (s_end(TXM_OFF_SYNTH_ON) |=> go_synth_on && !go_idle)
    else $error("synth on not chosen");
  a_post_tx: assert property (s_end(TXM_OFF_STAY_TX) |=> restart_preamble && !go_idle)
    else $error("stay in tx not chosen");
endmodule // txm_chk

bind txm_config_regs txm_chk #(.CHANNEL_NUMBER_W(CHANNEL_NUMBER_W), .OUT_W(OUT_W)) u_chk (.clock(clock),
  .srst(srst), .req(req), .rvalid(rvalid), .msk_mode(msk_mode), .packet_done(packet_done),
  .cfg(cfg), .preamble_bytes(preamble_bytes), .msk_fraction(msk_fraction),
  .deviation_step(deviation_step), .go_idle(go_idle), .go_synth_on(go_synth_on),
  .restart_preamble(restart_preamble));
